// ===== dv/mac_port_model.sv
`timescale 1ns/1ps
module mac_port_model (
  input wire clk_sys,
  output logic [1:0] rx_byte_valid,
  output logic [1:0] rx_byte_first,
  output logic [15:0] rx_byte_data,
  output logic [1:0] rx_sfd,
  output logic [1:0] tx_byte_valid,
  output logic [1:0] tx_byte_first,
  output logic [15:0] tx_byte_data,
  output logic [1:0] tx_from_host,
  output logic [1:0] tx_sfd
);
  logic [7:0] frm [0:127];
  initial begin
    {rx_byte_valid, rx_byte_first, rx_sfd} = 6'h0;
    {tx_byte_valid, tx_byte_first, tx_from_host, tx_sfd} = 8'h0;
    rx_byte_data = 16'h0;
    tx_byte_data = 16'h0;
  end
  // frame image: mode 0 raw, 1 ipv6, 2 ipv4; nt tags shift fields
  task automatic build(input int md, input int nt, input logic [3:0] k,
      input logic [15:0] sq, input logic [7:0] dm, input logic [7:0] ttl,
      output int len);
    int o;
    int m;
    foreach (frm[i]) frm[i] = 8'h00;
    for (o = 0; o < nt; o++) {frm[12+4*o], frm[13+4*o]} = o ? 16'h88a8 :
      16'h8100;
    o = 4 * nt;
    if (md == 0) begin
      {frm[12+o], frm[13+o]} = 16'h88f7;
      m = 14;
    end else if (md == 1) begin
      {frm[12+o], frm[13+o], frm[14+o]} = 24'h86dd60;
      {frm[20+o], frm[21+o], frm[38+o], frm[39+o]} = 32'h1101ff02;
      {frm[52+o], frm[53+o], frm[56+o], frm[57+o]} = 32'h0181013f;
      m = 62;
    end else begin
      {frm[12+o], frm[13+o], frm[14+o]} = 24'h080045;
      {frm[22+o], frm[23+o], frm[36+o], frm[37+o]} = {ttl, 24'h11013f};
      {frm[30+o], frm[31+o], frm[32+o], frm[33+o]} = 32'he0000181;
      m = 42;
    end
    m = m + o;
    frm[m] = {4'h0, k};
    frm[m+4] = dm;
    {frm[m+30], frm[m+31]} = sq;
    len = m + 32;
  endtask
  task automatic send(input int p, input bit tx, input bit h, input int n);
    int i;
    @(posedge clk_sys);
    if (!tx) begin
      rx_sfd[p] <= 1'b1;
      @(posedge clk_sys);
      rx_sfd[p] <= 1'b0;
    end
    for (i = 0; i < n; i++) begin
      if (tx) begin
        tx_byte_valid[p] <= 1'b1;
        tx_byte_first[p] <= i == 0;
        tx_byte_data[8*p +: 8] <= frm[i];
        tx_from_host[p] <= h;
      end else begin
        rx_byte_valid[p] <= 1'b1;
        rx_byte_first[p] <= i == 0;
        rx_byte_data[8*p +: 8] <= frm[i];
      end
      @(posedge clk_sys);
    end
    {rx_byte_valid, rx_byte_first, tx_byte_valid, tx_byte_first} <= 8'h0;
    if (tx) tx_byte_data[8*p +: 8] <= ~frm[n-1];
    else rx_byte_data[8*p +: 8] <= ~frm[n-1];
    if (tx) begin
      // delimiter only once the parsed frame has armed the port
      @(posedge clk_sys);
      tx_sfd[p] <= 1'b1;
      @(posedge clk_sys);
      tx_sfd[p] <= 1'b0;
    end
  endtask
endmodule // mac_port_model

// ===== dv/ptp_detector_checker.sv
`timescale 1ns/1ps
`include "ptp_detector_defs.vh"
module ptp_detector_checker (
  input wire clk_sys,
  input wire sys_rst,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire evt_ready,
  input wire evt_valid,
  input wire [31:0] evt_timestamp,
  input wire [1:0] evt_port,
  input wire [3:0] evt_type,
  input wire [15:0] evt_seq_id
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  evt_hold_a: assert property (
    evt_valid && !evt_ready |=> evt_valid &&
    $stable({evt_timestamp, evt_seq_id, evt_port, evt_type}))
    else $error("event dropped or changed before acceptance");
  evt_port_a: assert property (
    evt_valid |-> evt_port == 2'h1 || evt_port == 2'h2)
    else $error("event port out of range");
  evt_kind_a: assert property (
    evt_valid |-> evt_type == `EVT_RX || evt_type == `EVT_TX)
    else $error("event type code unknown");
  apb_wait_a: assert property (
    psel && !penable |=> !pready ##1 pready)
    else $error("access not answered after one wait");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  err_pair_a: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  unmapped_a: assert property (
    pready && !pwrite && paddr > 8'h20 |-> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  mapped_a: assert property (
    pready && paddr < 8'h20 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
endmodule // ptp_detector_checker

bind ptp_packet_timestamp_detector ptp_detector_checker u_chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .evt_ready(evt_ready), .evt_valid(evt_valid),
  .evt_timestamp(evt_timestamp), .evt_port(evt_port),
  .evt_type(evt_type), .evt_seq_id(evt_seq_id)
);

// ===== dv/testbench.sv
`timescale 1ns/1ps
`include "ptp_detector_defs.vh"
module testbench;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, evt_valid;
  logic ref_clk = 1'b0;
  logic [31:0] ts_value = 32'h0, evt_timestamp;
  logic evt_ready = 1'b0;
  logic [1:0] evt_port;
  logic [3:0] evt_type, evt_msg_type;
  logic [15:0] evt_seq_id;
  logic [7:0] evt_domain;
  wire [1:0] rxv, rxf, rxs, txv, txf, txh, txs;
  wire [15:0] rxd, txd;
  int bad_count = 0, check_count = 0, seq = 0, m, t;
  logic [1:0] rdiv = 2'h0;
  localparam [31:0] CTL = 32'h000b_0037;
  localparam [31:0] ADR = 32'h0004_0042;

  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    rdiv <= (rdiv == 2'h2) ? 2'h0 : rdiv + 2'h1;
    if (rdiv == 2'h2) ref_clk <= ~ref_clk;
  end

  ptp_packet_timestamp_detector u_ptp_packet_timestamp_detector (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timestamp_ref_clock(ref_clk),
    .ts_value(ts_value), .rx_byte_valid(rxv), .rx_byte_first(rxf),
    .rx_byte_data(rxd), .rx_sfd(rxs), .tx_byte_valid(txv),
    .tx_byte_first(txf), .tx_byte_data(txd), .tx_from_host(txh),
    .tx_sfd(txs), .evt_ready(evt_ready), .evt_valid(evt_valid),
    .evt_timestamp(evt_timestamp), .evt_port(evt_port),
    .evt_type(evt_type), .evt_msg_type(evt_msg_type),
    .evt_seq_id(evt_seq_id), .evt_domain(evt_domain));
  mac_port_model u_mac_port_model (
    .clk_sys(clk_sys), .rx_byte_valid(rxv), .rx_byte_first(rxf),
    .rx_byte_data(rxd), .rx_sfd(rxs), .tx_byte_valid(txv),
    .tx_byte_first(txf), .tx_byte_data(txd), .tx_from_host(txh),
    .tx_sfd(txs));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x,
      input logic xe);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    check(q, x);
    check(e, xe);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  // one frame on port p; ok says whether an event must follow
  task automatic run(input int p, input bit tx, input bit h, input int md,
      input int nt, input logic [3:0] k, input logic [7:0] ttl,
      input bit ok);
    int n;
    int len;
    logic [31:0] ts;
    logic [31:0] x;
    seq++;
    ts = 32'h8000_0000 + seq * 32'h111;
    x = {tx ? `EVT_TX : `EVT_RX, k, seq[15:0], seq[7:0] ^ 8'h5a};
    ts_value <= ts;
    u_mac_port_model.build(md, nt, k, seq[15:0], x[7:0], ttl, len);
    u_mac_port_model.send(p, tx, h, len);
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (evt_valid !== 1'b1 && n < 40);
    check(evt_valid, ok);
    if (ok) begin
      repeat (2) @(posedge clk_sys);
      check({evt_type, evt_msg_type, evt_seq_id, evt_domain}, x);
      check(evt_timestamp, ts);
      check(evt_port, p + 1);
      evt_ready <= 1'b1;
      @(posedge clk_sys);
      evt_ready <= 1'b0;
    end
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    end_sim;
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(8'h08, `RST_SYNC_TYPES, 1'b0);
    rd(8'h1c, `RST_VLAN_TYPES, 1'b0);
    rd(8'h44, 32'h0, 1'b1);
    wr(8'h00, CTL);
    wr(8'h04, ADR);
    wr(8'h10, CTL);
    wr(8'h14, ADR);
    rd(8'h14, ADR, 1'b0);
    for (m = 0; m < 3; m++)
      for (t = 0; t < 3; t++)
        run(1, 1, 1, m, t, 4'h0, 8'h00, 1'b1);
    run(0, 0, 0, 0, 0, 4'h3, 8'h00, 1'b1);
    run(0, 0, 0, 2, 1, 4'h1, 8'h00, 1'b1);
    run(0, 1, 0, 0, 0, 4'h0, 8'h00, 1'b0);
    run(1, 1, 1, 1, 0, 4'h2, 8'h00, 1'b0);
    run(1, 1, 1, 2, 0, 4'h0, 8'h05, 1'b0);
    wr(8'h10, CTL ^ 32'h41);
    run(1, 1, 1, 2, 0, 4'h0, 8'h05, 1'b1);
    run(1, 1, 1, 0, 0, 4'h0, 8'h00, 1'b0);
    run(0, 1, 1, 1, 2, 4'h3, 8'h00, 1'b1);
    rd(`OFS_STATUS, 32'h000d_0000, 1'b0);
    end_sim;
  end
endmodule // testbench

// ===== hw/ptp_detector_defs.vh
`ifndef PTP_DETECTOR_DEFS_VH
`define PTP_DETECTOR_DEFS_VH
// register byte offsets, port n at n*PORT_STRIDE
`define OFS_SYNC_CTL 8'h00
`define OFS_ADDR_CTL 8'h04
`define OFS_SYNC_TYPES 8'h08
`define OFS_VLAN_TYPES 8'h0c
`define OFS_PORT_STRIDE 8'h10
`define OFS_STATUS 8'h20
// port_sync_control_reg fields
`define CTL_RAW_EN 0
`define CTL_IPV6_EN 1
`define CTL_IPV4_EN 2
`define CTL_TYPE_B_EN 3
`define CTL_VLAN_A_EN 4
`define CTL_VLAN_B_EN 5
`define CTL_HOP_ACCEPT 6
`define CTL_MSG_MASK_LSB 16
// port_sync_addr_control_reg fields
`define ADR_UNICAST 0
`define ADR_G129 1
`define ADR_G130 2
`define ADR_G131 3
`define ADR_G132 4
`define ADR_G107 5
`define ADR_EVT_PORT 6
`define ADR_GEN_PORT 7
`define ADR_SCOPE_LSB 16
// reset values
`define RST_SYNC_CTL 32'h0000_0000
`define RST_ADDR_CTL 32'h0000_0000
`define RST_SYNC_TYPES 32'h0000_88f7
`define RST_VLAN_TYPES 32'h88a8_8100
// event type codes
`define EVT_RX 4'h3
`define EVT_TX 4'h4
// fixed field values
`define ETH_IPV6 16'h86dd
`define ETH_IPV4 16'h0800
`define IP_UDP 8'h11
`define MSG_OFS_RAW 8'h0e
`define MSG_OFS_IPV6 8'h3e
`define MSG_OFS_IPV4 8'h2a
`endif

// ===== hw/ptp_packet_timestamp_detector.v
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "ptp_detector_defs.vh"

// byte-wise frame classifier, one per path
module sync_frame_parser #(
  parameter HOST_ONLY = 0
) (
  input wire clk_sys,
  input wire sys_rst,
  input wire byte_valid,
  input wire byte_first,
  input wire [7:0] byte_data,
  input wire src_is_host,
  input wire [31:0] ctl,
  input wire [31:0] adr,
  input wire [31:0] types,
  input wire [31:0] vlans,
  output reg match_r,
  output reg [3:0] msg_r,
  output reg [15:0] seq_r,
  output reg [7:0] dom_r
);
  localparam M_NONE = 2'd0;
  localparam M_RAW = 2'd1;
  localparam M_V6 = 2'd2;
  localparam M_V4 = 2'd3;
  reg [7:0] cnt_r;
  reg [1:0] tags_r;
  reg [1:0] mode_r;
  reg ok_r;
  reg done_r;
  reg host_r;
  reg [7:0] hi_r;
  wire [7:0] idx = byte_first ? 8'h00 : cnt_r;
  // tags_r: 1 tag a, 2 tag b, 3 tag a then b
  wire [7:0] shift = (tags_r == 2'd0) ? 8'h00 :
    ((tags_r == 2'd3) ? 8'h08 : 8'h04);
  wire [7:0] rel = idx - shift;
  wire [15:0] pair = {hi_r, byte_data};
  wire v6 = (mode_r == M_V6);
  wire v4 = (mode_r == M_V4);
  wire uni = adr[`ADR_UNICAST];
  wire [7:0] base = v6 ? `MSG_OFS_IPV6 : (v4 ? `MSG_OFS_IPV4 :
    `MSG_OFS_RAW);
  wire [7:0] m = rel - base;
  wire grp_ok = (pair == 16'h0181 && adr[`ADR_G129]) ||
    (pair == 16'h0182 && adr[`ADR_G130]) ||
    (pair == 16'h0183 && adr[`ADR_G131]) ||
    (pair == 16'h0184 && adr[`ADR_G132]) ||
    (pair == 16'h006b && adr[`ADR_G107]);
  wire port_ok = (pair == 16'h013f && adr[`ADR_EVT_PORT]) ||
    (pair == 16'h0140 && adr[`ADR_GEN_PORT]);
  wire [15:0] scope = adr[31:`ADR_SCOPE_LSB];
  wire [15:0] kinds = ctl[31:`CTL_MSG_MASK_LSB];
  reg fail;
  always @* begin
    fail = 1'b0;
    if (v6) begin
      if (rel == 8'd14 && byte_data[7:4] != 4'h6) fail = 1'b1;
      if (rel == 8'd20 && byte_data != `IP_UDP) fail = 1'b1;
      if (rel == 8'd21 && byte_data != 8'h01) fail = 1'b1;
      if (!uni) begin
        if (rel == 8'd38 && byte_data != 8'hff) fail = 1'b1;
        if (rel == 8'd39 && (byte_data[7:4] != 4'h0 ||
          !scope[byte_data[3:0]])) fail = 1'b1;
        if (rel >= 8'd40 && rel <= 8'd51 && byte_data != 8'h00)
          fail = 1'b1;
        if (rel == 8'd53 && !grp_ok) fail = 1'b1;
      end
      if (rel == 8'd57 && !port_ok) fail = 1'b1;
    end
    if (v4) begin
      if (rel == 8'd14 && byte_data != 8'h45) fail = 1'b1;
      if (rel == 8'd20 && byte_data[4:0] != 5'h00) fail = 1'b1;
      if (rel == 8'd21 && byte_data != 8'h00) fail = 1'b1;
      if (rel == 8'd22 && byte_data != 8'h00 && !ctl[`CTL_HOP_ACCEPT])
        fail = 1'b1;
      if (rel == 8'd23 && byte_data != `IP_UDP) fail = 1'b1;
      if (!uni) begin
        if (rel == 8'd30 && byte_data != 8'he0) fail = 1'b1;
        if (rel == 8'd31 && byte_data != 8'h00) fail = 1'b1;
        if (rel == 8'd33 && !grp_ok) fail = 1'b1;
      end
      if (rel == 8'd37 && !port_ok) fail = 1'b1;
    end
  end
  wire ok_now = byte_first ? 1'b1 : ok_r;
  wire host_now = byte_first ? src_is_host : host_r;
  wire live = byte_valid && ok_now && !(done_r && !byte_first);
  wire tag_a = ctl[`CTL_VLAN_A_EN] && pair == vlans[15:0];
  wire tag_b = ctl[`CTL_VLAN_B_EN] && pair == vlans[31:16];
  wire raw_hit = pair == types[15:0] ||
    (ctl[`CTL_TYPE_B_EN] && pair == types[31:16]);
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt_r <= 8'h00;
      tags_r <= 2'd0;
      mode_r <= M_NONE;
      ok_r <= 1'b0;
      done_r <= 1'b1;
      host_r <= 1'b0;
      hi_r <= 8'h00;
      match_r <= 1'b0;
      msg_r <= 4'h0;
      seq_r <= 16'h0000;
      dom_r <= 8'h00;
    end else begin
      match_r <= 1'b0;
      if (byte_valid) begin
        hi_r <= byte_data;
        if (idx != 8'hff) cnt_r <= idx + 8'h01;
        if (byte_first) begin
          tags_r <= 2'd0;
          mode_r <= M_NONE;
          done_r <= 1'b0;
          host_r <= src_is_host;
        end
        ok_r <= ok_now && !fail;
      end
      if (live && mode_r == M_NONE && rel == 8'd13) begin
        // each tag pushes later fields down by four bytes
        if (tags_r == 2'd0 && (tag_a || tag_b)) begin
          tags_r <= {1'b0, 1'b1} + {1'b0, tag_b && !tag_a};
        end else if (tags_r == 2'd1 && tag_b) begin
          tags_r <= 2'd3;
        end else if (ctl[`CTL_RAW_EN] && raw_hit) begin
          mode_r <= M_RAW;
        end else if (ctl[`CTL_IPV6_EN] && pair == `ETH_IPV6) begin
          mode_r <= M_V6;
        end else if (ctl[`CTL_IPV4_EN] && pair == `ETH_IPV4) begin
          mode_r <= M_V4;
        end else begin
          ok_r <= 1'b0;
        end
      end
      if (live && mode_r != M_NONE && !fail) begin
        if (m == 8'd0) msg_r <= byte_data[3:0];
        if (m == 8'd4) dom_r <= byte_data;
        if (m == 8'd30) seq_r[15:8] <= byte_data;
        if (m == 8'd31) begin
          seq_r[7:0] <= byte_data;
          done_r <= 1'b1;
          match_r <= kinds[msg_r] &&
            (host_now || HOST_ONLY == 0);
        end
      end
    end
  end
endmodule // sync_frame_parser

module ptp_packet_timestamp_detector #(
  parameter NPORTS = 2
) (
  input wire clk_sys,
  input wire sys_rst,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire timestamp_ref_clock,
  input wire [31:0] ts_value,
  input wire [NPORTS-1:0] rx_byte_valid,
  input wire [NPORTS-1:0] rx_byte_first,
  input wire [NPORTS*8-1:0] rx_byte_data,
  input wire [NPORTS-1:0] rx_sfd,
  input wire [NPORTS-1:0] tx_byte_valid,
  input wire [NPORTS-1:0] tx_byte_first,
  input wire [NPORTS*8-1:0] tx_byte_data,
  input wire [NPORTS-1:0] tx_from_host,
  input wire [NPORTS-1:0] tx_sfd,
  input wire evt_ready,
  output reg evt_valid,
  output reg [31:0] evt_timestamp,
  output reg [1:0] evt_port,
  output reg [3:0] evt_type,
  output reg [3:0] evt_msg_type,
  output reg [15:0] evt_seq_id,
  output reg [7:0] evt_domain
);
  localparam NS = 2 * NPORTS;
  reg [31:0] ctl_r [0:NPORTS-1];
  reg [31:0] adr_r [0:NPORTS-1];
  reg [31:0] typ_r [0:NPORTS-1];
  reg [31:0] vln_r [0:NPORTS-1];
  reg [15:0] evt_cnt_r;
  reg ref_q_r;
  wire ref_edge = timestamp_ref_clock ^ ref_q_r;
  wire [NS-1:0] pend;
  wire [NS*32-1:0] s_ts;
  wire [NS*4-1:0] s_msg;
  wire [NS*16-1:0] s_seq;
  wire [NS*8-1:0] s_dom;
  wire free = !evt_valid || evt_ready;
  wire [NS-1:0] gnt = pend & (~pend + 1'b1) & {NS{free}};
  // apb: one wait state, pready from a flop
  wire acc = psel && penable && pready;
  integer i;
  reg [31:0] rd;
  reg hit;
  always @* begin
    rd = 32'h0000_0000;
    hit = 1'b0;
    for (i = 0; i < NPORTS; i = i + 1) begin
      if (paddr == `OFS_SYNC_CTL + i * `OFS_PORT_STRIDE) begin
        rd = ctl_r[i];
        hit = 1'b1;
      end else if (paddr == `OFS_ADDR_CTL + i * `OFS_PORT_STRIDE) begin
        rd = adr_r[i];
        hit = 1'b1;
      end else if (paddr == `OFS_SYNC_TYPES + i * `OFS_PORT_STRIDE) begin
        rd = typ_r[i];
        hit = 1'b1;
      end else if (paddr == `OFS_VLAN_TYPES + i * `OFS_PORT_STRIDE) begin
        rd = vln_r[i];
        hit = 1'b1;
      end
    end
    if (paddr == `OFS_STATUS) begin
      rd = {evt_cnt_r, {(16 - NS){1'b0}}, pend};
      hit = 1'b1;
    end
  end
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      ref_q_r <= 1'b0;
      for (i = 0; i < NPORTS; i = i + 1) begin
        ctl_r[i] <= `RST_SYNC_CTL;
        adr_r[i] <= `RST_ADDR_CTL;
        typ_r[i] <= `RST_SYNC_TYPES;
        vln_r[i] <= `RST_VLAN_TYPES;
      end
    end else begin
      ref_q_r <= timestamp_ref_clock;
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !hit;
      prdata <= (psel && !pwrite) ? rd : 32'h0000_0000;
      if (acc && pwrite) begin
        for (i = 0; i < NPORTS; i = i + 1) begin
          if (paddr == `OFS_SYNC_CTL + i * `OFS_PORT_STRIDE)
            ctl_r[i] <= pwdata;
          else if (paddr == `OFS_ADDR_CTL + i * `OFS_PORT_STRIDE)
            adr_r[i] <= pwdata;
          else if (paddr == `OFS_SYNC_TYPES + i * `OFS_PORT_STRIDE)
            typ_r[i] <= pwdata;
          else if (paddr == `OFS_VLAN_TYPES + i * `OFS_PORT_STRIDE)
            vln_r[i] <= pwdata;
        end
      end
    end
  end
  genvar p;
  generate
    for (p = 0; p < NPORTS; p = p + 1) begin : port
      wire rx_hit;
      wire tx_hit;
      wire [3:0] rx_msg;
      wire [3:0] tx_msg;
      wire [15:0] rx_seq;
      wire [15:0] tx_seq;
      wire [7:0] rx_dom;
      wire [7:0] tx_dom;
      reg rx_wait_r, rx_tsv_r, tx_arm_r, tx_wait_r;
      reg [31:0] rx_ts_r;
      reg [3:0] arm_msg_r;
      reg [15:0] arm_seq_r;
      reg [7:0] arm_dom_r;
      reg rp_r, tp_r;
      reg [31:0] rp_ts_r, tp_ts_r;
      reg [3:0] rp_msg_r, tp_msg_r;
      reg [15:0] rp_seq_r, tp_seq_r;
      reg [7:0] rp_dom_r, tp_dom_r;
      wire rx_push = rx_hit && rx_tsv_r;
      wire tx_push = tx_wait_r && ref_edge;
      sync_frame_parser #(.HOST_ONLY(0)) rx_parse (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .byte_valid(rx_byte_valid[p]),
        .byte_first(rx_byte_first[p]),
        .byte_data(rx_byte_data[p*8 +: 8]),
        .src_is_host(1'b1),
        .ctl(ctl_r[p]),
        .adr(adr_r[p]),
        .types(typ_r[p]),
        .vlans(vln_r[p]),
        .match_r(rx_hit),
        .msg_r(rx_msg),
        .seq_r(rx_seq),
        .dom_r(rx_dom)
      );
      sync_frame_parser #(.HOST_ONLY(1)) tx_parse (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .byte_valid(tx_byte_valid[p]),
        .byte_first(tx_byte_first[p]),
        .byte_data(tx_byte_data[p*8 +: 8]),
        .src_is_host(tx_from_host[p]),
        .ctl(ctl_r[p]),
        .adr(adr_r[p]),
        .types(typ_r[p]),
        .vlans(vln_r[p]),
        .match_r(tx_hit),
        .msg_r(tx_msg),
        .seq_r(tx_seq),
        .dom_r(tx_dom)
      );
      always @(posedge clk_sys) begin
        if (sys_rst) begin
          rx_wait_r <= 1'b0;
          rx_tsv_r <= 1'b0;
          rx_ts_r <= 32'h0000_0000;
          tx_arm_r <= 1'b0;
          tx_wait_r <= 1'b0;
          arm_msg_r <= 4'h0;
          arm_seq_r <= 16'h0000;
          arm_dom_r <= 8'h00;
        end else begin
          // rx stamp taken for every frame at the next ref edge
          if (rx_sfd[p]) begin
            rx_wait_r <= 1'b1;
            rx_tsv_r <= 1'b0;
          end else if (rx_wait_r && ref_edge) begin
            rx_wait_r <= 1'b0;
            rx_tsv_r <= 1'b1;
            rx_ts_r <= ts_value;
          end else if (rx_push || (rx_byte_first[p] &&
            rx_byte_valid[p])) begin
            rx_tsv_r <= rx_push ? 1'b0 : rx_tsv_r;
          end
          if (tx_hit) begin
            tx_arm_r <= 1'b1;
            arm_msg_r <= tx_msg;
            arm_seq_r <= tx_seq;
            arm_dom_r <= tx_dom;
          end else if (tx_sfd[p] && tx_arm_r) begin
            tx_arm_r <= 1'b0;
            tx_wait_r <= 1'b1;
          end else if (tx_push) begin
            tx_wait_r <= 1'b0;
          end
        end
      end
      always @(posedge clk_sys) begin
        if (sys_rst) begin
          rp_r <= 1'b0;
          tp_r <= 1'b0;
          rp_ts_r <= 32'h0000_0000;
          tp_ts_r <= 32'h0000_0000;
          rp_msg_r <= 4'h0;
          tp_msg_r <= 4'h0;
          rp_seq_r <= 16'h0000;
          tp_seq_r <= 16'h0000;
          rp_dom_r <= 8'h00;
          tp_dom_r <= 8'h00;
        end else begin
          // a new push wins over the grant clearing the slot
          if (rx_push) begin
            rp_r <= 1'b1;
            rp_ts_r <= rx_ts_r;
            rp_msg_r <= rx_msg;
            rp_seq_r <= rx_seq;
            rp_dom_r <= rx_dom;
          end else if (gnt[2*p]) begin
            rp_r <= 1'b0;
          end
          if (tx_push) begin
            tp_r <= 1'b1;
            tp_ts_r <= ts_value;
            tp_msg_r <= arm_msg_r;
            tp_seq_r <= arm_seq_r;
            tp_dom_r <= arm_dom_r;
          end else if (gnt[2*p+1]) begin
            tp_r <= 1'b0;
          end
        end
      end
      assign pend[2*p +: 2] = {tp_r, rp_r};
      assign s_ts[64*p +: 64] = {tp_ts_r, rp_ts_r};
      assign s_msg[8*p +: 8] = {tp_msg_r, rp_msg_r};
      assign s_seq[32*p +: 32] = {tp_seq_r, rp_seq_r};
      assign s_dom[16*p +: 16] = {tp_dom_r, rp_dom_r};
    end
  endgenerate
  integer s;
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      evt_valid <= 1'b0;
      evt_timestamp <= 32'h0000_0000;
      evt_port <= 2'd0;
      evt_type <= 4'h0;
      evt_msg_type <= 4'h0;
      evt_seq_id <= 16'h0000;
      evt_domain <= 8'h00;
      evt_cnt_r <= 16'h0000;
    end else begin
      if (free) evt_valid <= |gnt;
      if (|gnt) evt_cnt_r <= evt_cnt_r + 16'h0001;
      for (s = 0; s < NS; s = s + 1) begin
        if (gnt[s]) begin
          evt_timestamp <= s_ts[32*s +: 32];
          evt_port <= s[2:1] + 2'd1;
          evt_type <= s[0] ? `EVT_TX : `EVT_RX;
          evt_msg_type <= s_msg[4*s +: 4];
          evt_seq_id <= s_seq[16*s +: 16];
          evt_domain <= s_dom[8*s +: 8];
        end
      end
    end
  end
endmodule // ptp_packet_timestamp_detector
